// [hw/rct_map.vh]
// Register map, field positions and timing counts for reset-cause tracking
`ifndef RCT_MAP_VH
`define RCT_MAP_VH

// ----------------------------------------------------------------------
// Register location
// ----------------------------------------------------------------------
`define RCT_SFR_ADDR      8'hef
`define RCT_SFR_PAGE      8'h00

// ----------------------------------------------------------------------
// Field positions of reset_cause
// ----------------------------------------------------------------------
`define RCT_BIT_UNUSED    7
`define RCT_BIT_FLASH     6
`define RCT_BIT_COMP      5
`define RCT_BIT_SOFT      4
`define RCT_BIT_WDOG      3
`define RCT_BIT_CLKLOSS   2
`define RCT_BIT_POWER     1
`define RCT_BIT_PIN       0

// Flags after a power-on reset: only the power-on flag is set
`define RCT_FLAGS_POR     8'h02
`define RCT_ENABLES_POR   3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RCT_CLK_MHZ       20
// Length of the internal system reset pulse, least time
`define RCT_HOLD_NS       1000
`define RCT_HOLD_CYC      ((`RCT_HOLD_NS * `RCT_CLK_MHZ + 999) / 1000)
// Monitored clock may sit still this long before a clock-loss reset
`define RCT_CLKLOSS_NS    100000
`define RCT_CLKLOSS_CYC   ((`RCT_CLKLOSS_NS * `RCT_CLK_MHZ) / 1000)

`endif

// [hw/rct_reset_cause.v]
// Reset-cause register, reset-source enables and system reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rct_map.vh"

// Contract
// - Register sits at address 0xEF, page 0x00
// - Bit 6 reads flash fault cause, read-only
// - Bit 5 write enables comparator low reset
// - Bit 5 reads comparator cause flag
// - Bit 4 write of one forces reset
// - Bit 4 reads one after software reset
// - Bit 3 reads watchdog cause, writes ignored
// - Bit 2 write of one enables clock-loss detector
// - Enabled detector resets on stopped clock
// - Bit 2 reads one after clock-loss reset
// - Bit 1 write enables supply monitor reset
// - Bit 1 set on power-on or monitor reset
// - Other flags meaningless while power flag set
// - Bit 0 reads pin reset cause, read-only
// - Comparator enabled: plus below minus resets
// - Illegal flash access resets, sets flash flag
module rct_reset_cause (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_page,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  input  wire       pin_reset_n,
  input  wire       comparator_out,
  input  wire       vdd_above_threshold,
  input  wire       monitored_clk,
  input  wire       flash_fault_evt,
  input  wire       watchdog_overflow,
  output reg        sys_reset_n,
  output reg        comparator_reset_en,
  output reg        clock_loss_en,
  output reg        vdd_monitor_reset_en
);

  // --------------------------------------------------------------------
  // Constants and state
  // --------------------------------------------------------------------
  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;
  localparam integer HOLD_CYC_I = `RCT_HOLD_CYC;
  localparam integer LOSS_CYC_I = `RCT_CLKLOSS_CYC;
  // Cut to the counter widths on purpose; both counts fit
  localparam [4:0]  HOLD_CYC    = HOLD_CYC_I[4:0];
  localparam [11:0] LOSS_CYC    = LOSS_CYC_I[11:0];

  reg  [1:0]  state_reg;
  reg  [4:0]  hold_cnt_reg;
  reg  [7:0]  cause_reg;
  reg  [7:0]  flags_reg;
  reg  [11:0] loss_cnt_reg;

  // --------------------------------------------------------------------
  // Synchronisers for asynchronous inputs
  // --------------------------------------------------------------------
  wire [3:0] async_in = {monitored_clk, vdd_above_threshold,
                         comparator_out, pin_reset_n};
  wire [3:0] sync_q;
  reg        mclk_prev_reg;
  wire       pin_low   = ~sync_q[0];
  wire       comp_out  = sync_q[1];
  wire       vdd_ok    = sync_q[2];
  wire       mclk_s    = sync_q[3];
  genvar     gi;

  // Reset to the idle levels: pin high, comparator high, supply good
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg s1_reg;
      reg s2_reg;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
        end else begin
          s1_reg <= async_in[gi];
          s2_reg <= s1_reg;
        end
      end
      assign sync_q[gi] = s2_reg;
    end
  endgenerate

  // Starts at the synchroniser's reset level, so reset shows no false edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_prev_reg <= 1'b1;
    end else begin
      mclk_prev_reg <= mclk_s;
    end
  end

  // --------------------------------------------------------------------
  // Clock-loss detector
  // --------------------------------------------------------------------
  // Counts cycles since the last edge of the monitored clock; it only
  // runs while enabled so that a disabled detector never fires late.
  wire mclk_edge = mclk_s ^ mclk_prev_reg;
  wire loss_hit  = clock_loss_en && (loss_cnt_reg >= LOSS_CYC);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt_reg <= 12'h000;
    end else if (!clock_loss_en || mclk_edge || state_reg == ST_HOLD) begin
      loss_cnt_reg <= 12'h000;
    end else if (!loss_hit) begin
      loss_cnt_reg <= loss_cnt_reg + 12'h001;
    end
  end

  // --------------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------------
  wire sel = (sfr_addr == `RCT_SFR_ADDR) &&
             (sfr_page == `RCT_SFR_PAGE);
  wire wr  = sel && sfr_wr && (state_reg == ST_RUN);
  wire soft_force = wr && sfr_wdata[`RCT_BIT_SOFT];

  // Flags show the last cause; bit 7 is forced to zero
  wire [7:0] read_val = {1'b0, flags_reg[6:0]};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sel && sfr_rd) begin
      sfr_rdata <= read_val;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Cause detection, highest priority first
  // --------------------------------------------------------------------
  wire vdd_hit  = vdd_monitor_reset_en && !vdd_ok;
  wire comp_hit = comparator_reset_en && !comp_out;
  reg  [7:0] cause_now;

  always @* begin
    cause_now = 8'h00;
    if (vdd_hit) begin
      cause_now[`RCT_BIT_POWER] = 1'b1;
    end else if (pin_low) begin
      cause_now[`RCT_BIT_PIN] = 1'b1;
    end else if (loss_hit) begin
      cause_now[`RCT_BIT_CLKLOSS] = 1'b1;
    end else if (flash_fault_evt) begin
      cause_now[`RCT_BIT_FLASH] = 1'b1;
    end else if (watchdog_overflow) begin
      cause_now[`RCT_BIT_WDOG] = 1'b1;
    end else if (comp_hit) begin
      cause_now[`RCT_BIT_COMP] = 1'b1;
    end else if (soft_force) begin
      cause_now[`RCT_BIT_SOFT] = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Reset sequencer, flags and enables
  // --------------------------------------------------------------------
  // The pin holds the sequencer in reset for as long as it stays low;
  // all other causes give one pulse of fixed length.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg            <= ST_RUN;
      hold_cnt_reg         <= 5'h00;
      cause_reg            <= 8'h00;
      flags_reg            <= `RCT_FLAGS_POR;
      sys_reset_n          <= 1'b0;
      comparator_reset_en  <= 1'b0;
      clock_loss_en        <= 1'b0;
      vdd_monitor_reset_en <= 1'b0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          sys_reset_n <= 1'b1;
          if (cause_now != 8'h00) begin
            state_reg            <= ST_HOLD;
            cause_reg            <= cause_now;
            hold_cnt_reg         <= HOLD_CYC;
            sys_reset_n          <= 1'b0;
            // A system reset returns every source enable to off
            comparator_reset_en  <= 1'b0;
            clock_loss_en        <= 1'b0;
            vdd_monitor_reset_en <= 1'b0;
          end else if (wr) begin
            comparator_reset_en  <= sfr_wdata[`RCT_BIT_COMP];
            clock_loss_en        <= sfr_wdata[`RCT_BIT_CLKLOSS];
            vdd_monitor_reset_en <= sfr_wdata[`RCT_BIT_POWER];
          end
        end
        ST_HOLD: begin
          sys_reset_n <= 1'b0;
          if (hold_cnt_reg > 5'h01) begin
            hold_cnt_reg <= hold_cnt_reg - 5'h01;
          end else if (!pin_low) begin
            state_reg   <= ST_RUN;
            sys_reset_n <= 1'b1;
            // Only the cause of this reset is left set
            flags_reg   <= cause_reg;
          end
        end
        default: begin
          state_reg   <= ST_RUN;
          sys_reset_n <= 1'b0;
        end
      endcase
    end
  end

endmodule // rct_reset_cause

`default_nettype wire

// [test/rct_reset_cause_props.sv]
// Port assertions for the reset-cause register block
`timescale 1ns/1ps
`default_nettype none
module rct_reset_cause_props (
  input wire       clk,
  input wire       rst_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_page,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire       pin_reset_n,
  input wire       comparator_out,
  input wire       vdd_above_threshold,
  input wire       monitored_clk,
  input wire       flash_fault_evt,
  input wire       watchdog_overflow,
  input wire       sys_reset_n,
  input wire       comparator_reset_en,
  input wire       clock_loss_en,
  input wire       vdd_monitor_reset_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire       sel = sfr_addr == 8'hef && sfr_page == 8'h00;
  reg  [7:0] lo_cnt_reg;
  // Saturates so that a long pin reset cannot wrap the count; power-on
  // release is no sequencer pulse, so the count starts saturated
  always @(posedge clk or negedge rst_n)
    if (!rst_n) lo_cnt_reg <= 8'hff;
    else if (sys_reset_n) lo_cnt_reg <= 8'h00;
    else if (lo_cnt_reg != 8'hff) lo_cnt_reg <= lo_cnt_reg + 8'h01;
  sequence run_wr;
    sys_reset_n && sfr_wr && sel;
  endsequence
  sequence rd_pair;
    sys_reset_n && sfr_rd && sel ##1 sys_reset_n && sfr_rd && sel;
  endsequence
  soft_force_a: assert property (
    run_wr ##0 sfr_wdata[4] |=> !sys_reset_n)
    else $error("soft write gave no reset");
  en_write_a: assert property (
    run_wr ##0 !sfr_wdata[4] ##0 !watchdog_overflow && !flash_fault_evt
    |=> !sys_reset_n ||
    (comparator_reset_en == $past(sfr_wdata[5]) &&
     clock_loss_en == $past(sfr_wdata[2]) &&
     vdd_monitor_reset_en == $past(sfr_wdata[1])))
    else $error("enable write not applied");
  wdog_rst_a: assert property (
    sys_reset_n && watchdog_overflow |=> !sys_reset_n)
    else $error("watchdog gave no reset");
  flash_rst_a: assert property (
    sys_reset_n && flash_fault_evt |=> !sys_reset_n)
    else $error("flash fault gave no reset");
  comp_rst_a: assert property (
    (sys_reset_n && comparator_reset_en && !comparator_out)[*3]
    |=> !sys_reset_n)
    else $error("comparator no reset");
  en_clear_a: assert property (
    !sys_reset_n |-> !(comparator_reset_en || clock_loss_en ||
    vdd_monitor_reset_en))
    else $error("enable kept in reset");
  hold_len_a: assert property (
    $rose(sys_reset_n) && lo_cnt_reg != 8'h00 |-> lo_cnt_reg >= 8'h14)
    else $error("reset pulse too short");
  rd_idle_a: assert property (
    !(sfr_rd && sel) |=> sfr_rdata == 8'h00)
    else $error("read data without selected read");
  unused_bit_a: assert property (sfr_rdata[7] == 1'b0)
    else $error("unused bit read as one");
  rd_stable_a: assert property (rd_pair |=> $stable(sfr_rdata))
    else $error("flags changed outside reset exit");
endmodule // rct_reset_cause_props
`default_nettype wire

// [test/test_reset_cause_tracking.sv]
// Self-checking bench for reset-cause tracking
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t: got %h want %h", $time, a, b); end end
module test_reset_cause_tracking;
  logic       clk, rst_n, sfr_wr, sfr_rd, pin_reset_n, comparator_out;
  logic       vdd_above_threshold, flash_fault_evt, watchdog_overflow;
  logic       sys_reset_n, comparator_reset_en, clock_loss_en, mclk_run;
  logic       vdd_monitor_reset_en, monitored_clk = 1'b0;
  logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, rv;
  int         n_errors = 0, checks = 0, i;
  wire  [2:0] en_o = {comparator_reset_en, clock_loss_en,
                      vdd_monitor_reset_en};
  logic [7:0] row_en [0:6] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h00, 8'h02,
                               8'h04};
  logic [7:0] row_exp[0:6] = '{8'h08, 8'h40, 8'h10, 8'h20, 8'h01, 8'h02,
                               8'h04};
  logic [2:0] row_eo [0:6] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h1, 3'h2};
  rct_reset_cause u_rct_reset_cause (.clk(clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_reset_n(pin_reset_n),
    .comparator_out(comparator_out),
    .vdd_above_threshold(vdd_above_threshold),
    .monitored_clk(monitored_clk), .flash_fault_evt(flash_fault_evt),
    .watchdog_overflow(watchdog_overflow), .sys_reset_n(sys_reset_n),
    .comparator_reset_en(comparator_reset_en), .clock_loss_en(clock_loss_en),
    .vdd_monitor_reset_en(vdd_monitor_reset_en));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watched clock toggles every cycle; stopping it provokes clock loss
  always @(posedge clk)
    monitored_clk <= mclk_run ? ~monitored_clk : monitored_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 rv = sfr_rdata;
  endtask
  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (sys_reset_n !== lvl && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(sys_reset_n, lvl)
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    {rst_n, sfr_wr, sfr_rd, flash_fault_evt, watchdog_overflow} = '0;
    {pin_reset_n, comparator_out, vdd_above_threshold, mclk_run} = '1;
    {sfr_addr, sfr_page, sfr_wdata} = {8'hef, 8'h00, 8'h00};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'hef);
    `CHK(rv, 8'h02)
    for (i = 0; i < 7; i++) begin
      wr(8'hef, row_en[i]);
      `CHK(en_o, row_eo[i])
      @(posedge clk);
      watchdog_overflow <= i == 0;
      flash_fault_evt <= i == 1;
      comparator_out <= i != 3;
      pin_reset_n <= i != 4;
      vdd_above_threshold <= i != 5;
      mclk_run <= i != 6;
      @(posedge clk);
      {watchdog_overflow, flash_fault_evt} <= 2'b00;
      wait_lvl(1'b0);
      @(posedge clk);
      {pin_reset_n, comparator_out, vdd_above_threshold, mclk_run} <= 4'hf;
      wait_lvl(1'b1);
      rd(8'hef);
      `CHK(rv, row_exp[i])
    end
    wr(8'hee, 8'h10);
    repeat (3) @(posedge clk);
    #1 `CHK(sys_reset_n, 1'b1)
    rd(8'hee);
    `CHK(rv, 8'h00)
    wr(8'hef, 8'hc9);
    rd(8'hef);
    `CHK({en_o, rv}, {3'h0, 8'h04})
    wr(8'hef, 8'h10);
    wr(8'hef, 8'h26);
    wait_lvl(1'b1);
    rd(8'hef);
    `CHK({en_o, rv}, {3'h0, 8'h10})
    // Back-to-back reads must return the same flags
    @(posedge clk) sfr_rd <= 1'b1;
    repeat (2) @(posedge clk);
    sfr_rd <= 1'b0;
    #1 `CHK(sfr_rdata, 8'h10)
    // A force written on another page must not reset
    @(posedge clk) sfr_page <= 8'h01;
    wr(8'hef, 8'h10);
    repeat (3) @(posedge clk);
    #1 `CHK(sys_reset_n, 1'b1)
    @(posedge clk) sfr_page <= 8'h00;
    wr(8'hef, 8'h26);
    `CHK(en_o, 3'h7)
    // Mid-run power-on reset clears enables and leaves only the power flag
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'hef);
    `CHK({en_o, rv}, {3'h0, 8'h02})
    end_of_test();
  end
endmodule // test_reset_cause_tracking
bind rct_reset_cause rct_reset_cause_props u_rct_reset_cause_props (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .pin_reset_n(pin_reset_n),
  .comparator_out(comparator_out), .vdd_above_threshold(vdd_above_threshold),
  .monitored_clk(monitored_clk), .flash_fault_evt(flash_fault_evt),
  .watchdog_overflow(watchdog_overflow), .sys_reset_n(sys_reset_n),
  .comparator_reset_en(comparator_reset_en), .clock_loss_en(clock_loss_en),
  .vdd_monitor_reset_en(vdd_monitor_reset_en));
`default_nettype wire
